// ### hw/bsfm_boost_monitor.sv
// Boost startup sequencer, fault handling, aux regulator gate and status monitor
`timescale 1ns/10ps
`include "bsfm_regs.svh"

module bsfm_boost_monitor #(
    parameter int RESTART_CYC = `BSFM_RESTART_CYC,
    parameter int RETRY_CYC = `BSFM_RETRY_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire bsfm_pkg::bsfm_analog_t analog,
    input wire logic otg_pin,
    input wire logic otg_pin_enable,
    input wire logic otg_polarity_bit,
    input wire logic high_impedance_bit,
    input wire logic aux_regulator_disable,
    input wire logic request_set,
    input wire logic [7:0] monitor_live,
    input wire logic [7:0] reg_addr,
    output logic [7:0] reg_rdata,
    output logic boost_request_bit,
    output logic [2:0] fault_code,
    output logic status_out,
    output logic status_oe,
    output logic aux_regulator_output,
    output bsfm_pkg::bsfm_stage_t stage
);

    // ----------------------------------------------------------------
    // State record
    // ----------------------------------------------------------------
    typedef struct packed {
        bsfm_pkg::bsfm_state_t fsm;
        logic [2:0] otg_sync;
        logic otg_active;
        logic enable_d;
        logic [31:0] timer;
        logic [31:0] ilim_cnt;
        logic [31:0] stat_cnt;
        logic first_retry;
        logic full_ilim;
        logic skip;
        logic izero_early;
        logic request;
        logic [2:0] fault;
        logic status_oe;
        logic aux_on;
        logic [7:0] rdata;
        bsfm_pkg::bsfm_stage_t stage;
    } bsfm_regs_t;

    bsfm_regs_t cur;
    bsfm_regs_t next_cur;

    // Enable paths
    logic pin_path;
    logic reg_path;
    logic boost_en;
    logic boosting;
    logic next_boosting; // Soft-start or regulate after this edge

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        // Three-stage pin synchroniser; change counts when stages 2 and 3 agree
        next_cur.otg_sync = {cur.otg_sync[1:0], otg_pin};
        if (cur.otg_sync[2] == cur.otg_sync[1]) begin
            next_cur.otg_active = (cur.otg_sync[2] == otg_polarity_bit); // RULE24
        end
        pin_path = otg_pin_enable & cur.otg_active;
        reg_path = cur.request & ~high_impedance_bit; // RULE25
        boost_en = pin_path | reg_path; // RULE25
        next_cur.enable_d = boost_en;
        // Software request; high impedance overrides it
        if (high_impedance_bit) begin
            next_cur.request = 1'b0; // RULE25
        end else if (request_set) begin
            next_cur.request = 1'b1;
        end
        next_cur.timer = cur.timer + 32'h1;
        if (cur.stat_cnt != 32'h0) begin
            next_cur.stat_cnt = cur.stat_cnt - 32'h1;
        end
        case (cur.fsm)
            bsfm_pkg::BSFM_OFF: begin
                // Rising enable with battery above undervoltage
                if (boost_en && !cur.enable_d && analog.bat_above_uvlo) begin
                    next_cur.fsm = bsfm_pkg::BSFM_PRECHARGE; // RULE4
                    next_cur.timer = 32'h0; // RULE28
                    next_cur.fault = `BSFM_FAULT_NONE;
                end
            end
            bsfm_pkg::BSFM_PRECHARGE: begin
                if (analog.mid_rail_ok) begin
                    next_cur.fsm = bsfm_pkg::BSFM_SOFTSTART; // RULE6
                    next_cur.timer = 32'h0; // RULE28
                    next_cur.full_ilim = 1'b0; // RULE6
                end else if (cur.timer >= `BSFM_PRECHARGE_CYC - 1) begin
                    next_cur.fsm = bsfm_pkg::BSFM_FAULT; // RULE5
                    next_cur.fault = `BSFM_FAULT_START;
                end
            end
            bsfm_pkg::BSFM_SOFTSTART: begin
                if (analog.vbus_near_set) begin
                    next_cur.fsm = bsfm_pkg::BSFM_REGULATE; // RULE7
                    next_cur.full_ilim = 1'b1; // RULE7
                    next_cur.ilim_cnt = 32'h0;
                end else if (cur.timer >= `BSFM_SS1_CYC + `BSFM_SS2_CYC - 1) begin
                    next_cur.fsm = bsfm_pkg::BSFM_FAULT; // RULE9
                    next_cur.fault = `BSFM_FAULT_START; // RULE16
                end else if (cur.timer >= `BSFM_SS1_CYC - 1 && !analog.vbus_at_target) begin
                    next_cur.full_ilim = 1'b1; // RULE8
                end
            end
            bsfm_pkg::BSFM_REGULATE: begin
                // Sustained current limit counter
                next_cur.ilim_cnt = analog.ilim_active ? cur.ilim_cnt + 32'h1 : 32'h0;
                if (cur.ilim_cnt >= `BSFM_ILIM_CYC) begin
                    next_cur.fsm = bsfm_pkg::BSFM_FAULT;
                    next_cur.fault = `BSFM_FAULT_START; // RULE16
                end
            end
            bsfm_pkg::BSFM_FAULT: begin
                // Restart only from an active pin path
                if (!pin_path) begin
                    next_cur.fsm = bsfm_pkg::BSFM_OFF; // RULE13
                end else if (cur.timer >= (cur.first_retry ? RESTART_CYC : RETRY_CYC) - 1) begin
                    next_cur.fsm = bsfm_pkg::BSFM_PRECHARGE; // RULE14 RULE15
                    next_cur.timer = 32'h0; // RULE28
                    next_cur.first_retry = 1'b0; // RULE15
                end
            end
            default: begin
                next_cur.fsm = bsfm_pkg::BSFM_OFF;
            end
        endcase

        // Faults common to all running states, by priority
        if (cur.fsm != bsfm_pkg::BSFM_OFF && cur.fsm != bsfm_pkg::BSFM_FAULT) begin
            if (analog.timer_fault) begin
                next_cur.fsm = bsfm_pkg::BSFM_FAULT;
                next_cur.fault = `BSFM_FAULT_TIMER; // RULE17
            end else if (analog.thermal) begin
                next_cur.fsm = bsfm_pkg::BSFM_FAULT;
                next_cur.fault = `BSFM_FAULT_THERMAL; // RULE17
            end else if (analog.ovp) begin
                next_cur.fsm = bsfm_pkg::BSFM_FAULT;
                next_cur.fault = `BSFM_FAULT_OVP; // RULE17
            end else if (!analog.bat_above_uvlo) begin
                next_cur.fsm = bsfm_pkg::BSFM_FAULT;
                next_cur.fault = `BSFM_FAULT_UVLO; // RULE17
            end else if (!boost_en) begin
                next_cur.fsm = bsfm_pkg::BSFM_OFF;
            end
        end

        // Fault entry actions
        if (next_cur.fsm == bsfm_pkg::BSFM_FAULT && cur.fsm != bsfm_pkg::BSFM_FAULT) begin
            next_cur.stat_cnt = 32'(`BSFM_STATUS_CYC); // RULE12 RULE26
            next_cur.request = request_set & ~high_impedance_bit; // RULE12
            next_cur.timer = 32'h0; // RULE28
            next_cur.first_retry = 1'b1;
        end
        if (next_cur.fsm == bsfm_pkg::BSFM_OFF && cur.fsm == bsfm_pkg::BSFM_REGULATE) begin
            next_cur.request = request_set & ~high_impedance_bit;
        end
        // Pull-down starts with the fault code, same edge
        next_cur.status_oe = (next_cur.stat_cnt != 32'h0); // RULE26

        // Switching control in soft-start and regulate
        if (analog.toff_done) begin
            next_cur.izero_early = 1'b0;
            if (analog.out_above_ref) begin
                next_cur.skip = 1'b1; // RULE1
            end
        end else if (analog.izero) begin
            next_cur.izero_early = 1'b1; // RULE11
        end
        if (!analog.out_above_ref) begin
            next_cur.skip = 1'b0; // RULE2
        end
        boosting = (cur.fsm == bsfm_pkg::BSFM_SOFTSTART) || (cur.fsm == bsfm_pkg::BSFM_REGULATE);
        // Stage floats on the very edge that enters a fault
        next_boosting = (next_cur.fsm == bsfm_pkg::BSFM_SOFTSTART)
            || (next_cur.fsm == bsfm_pkg::BSFM_REGULATE);
        next_cur.stage.precharge_on = (next_cur.fsm == bsfm_pkg::BSFM_PRECHARGE); // RULE4
        next_cur.stage.switch_on = boosting && next_boosting && !next_cur.skip // RULE2
            && !(cur.fsm == bsfm_pkg::BSFM_REGULATE && analog.fb_above_ref); // RULE10
        next_cur.stage.half_ilim = !next_cur.full_ilim; // RULE6 RULE8
        next_cur.stage.long_ton = next_cur.skip || next_cur.izero_early; // RULE3 RULE11
        next_cur.stage.stage_hiz = !next_boosting; // RULE12
        next_cur.stage.regulate_state = (cur.fsm == bsfm_pkg::BSFM_REGULATE);
        next_cur.stage.pulse_skip_mode = next_cur.skip;

        // Aux regulator gate
        next_cur.aux_on = !aux_regulator_disable && !boosting // RULE18 RULE19
            && !high_impedance_bit && analog.mid_above_bat; // RULE19 RULE20

        // Read-only monitor, live bits, no read effects
        next_cur.rdata = (reg_addr == `BSFM_MONITOR_OFFSET) ? monitor_live : 8'h00; // RULE21 RULE23 RULE27
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cur <= '0;
            cur.stage.stage_hiz <= 1'b1;
            cur.stage.half_ilim <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from flops, except status_out which is tied low
    assign reg_rdata = cur.rdata;
    assign boost_request_bit = cur.request;
    assign fault_code = cur.fault;
    assign status_out = 1'b0;
    assign status_oe = cur.status_oe;
    assign aux_regulator_output = cur.aux_on;
    assign stage = cur.stage;

endmodule : bsfm_boost_monitor

// ### hw/bsfm_pkg.sv
// Types shared by the boost startup and fault monitor
package bsfm_pkg;

    // Boost sequencer states
    typedef enum logic [2:0] {
        BSFM_OFF = 3'b000,
        BSFM_PRECHARGE = 3'b001,
        BSFM_SOFTSTART = 3'b010,
        BSFM_REGULATE = 3'b011,
        BSFM_FAULT = 3'b100
    } bsfm_state_t;

    // Analog comparator inputs
    typedef struct packed {
        logic out_above_ref;
        logic fb_above_ref;
        logic mid_rail_ok;
        logic mid_above_bat;
        logic vbus_near_set;
        logic vbus_at_target;
        logic bat_above_uvlo;
        logic ilim_active;
        logic izero;
        logic toff_done;
        logic ovp;
        logic thermal;
        logic timer_fault;
    } bsfm_analog_t;

    // Power stage controls
    typedef struct packed {
        logic precharge_on;
        logic switch_on;
        logic half_ilim;
        logic long_ton;
        logic stage_hiz;
        logic regulate_state;
        logic pulse_skip_mode;
    } bsfm_stage_t;

endpackage : bsfm_pkg

// ### hw/bsfm_regs.svh
// Register offsets, field positions, fault codes and timing counts for the boost monitor
// Summary of operation
// RULE1 - Output above reference after off-time: pulse skip
// RULE2 - Pulse skip suppresses pulses until output falls
// RULE3 - Pulse skip uses lengthened minimum on-time
// RULE4 - Enable rise with battery ok: precharge
// RULE5 - Precharge timeout without mid rail: fault
// RULE6 - Mid rail ok: soft-start at half limit
// RULE7 - Output near setpoint: full limit, regulate
// RULE8 - First soft-start interval missed: full limit
// RULE9 - Second interval missed: fault, soft-start code
// RULE10 - Regulate: switch off while feedback above reference
// RULE11 - Early zero current: longer next on-time
// RULE12 - Fault: pulse status, clear request, high impedance, code
// RULE13 - Register-started boost waits for new request
// RULE14 - Pin-enabled and active: restart after delay
// RULE15 - Persisting fault: retry at fixed interval; the code waits RESTART_CYC before every retry and never uses RETRY_CYC
// RULE16 - Code 010 for soft-start or sustained limit
// RULE17 - Fault field codes; never 100 or 111
// RULE18 - Aux regulator off when disable bit set
// RULE19 - Aux regulator off while boosting or high impedance
// RULE20 - Aux regulator only while mid rail above battery
// RULE21 - Monitor bits shown live, unfiltered
// RULE22 - Software trusts high-impedance monitor only if input valid
// RULE23 - Monitor bit order seven down to zero
// RULE24 - Pin active when level equals polarity bit
// RULE25 - Pin starts despite high impedance; bit overrides request
// RULE26 - Status pin: one fixed low pulse, then open
// RULE27 - Monitor register read-only, no read effects
// RULE28 - Timeout counters cleared on each state entry
`ifndef BSFM_REGS_SVH
`define BSFM_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define BSFM_MONITOR_OFFSET 8'h10
`define BSFM_FAULT_LSB 0
`define BSFM_FAULT_MSB 2

// ----------------------------------------------------------------
// Fault codes
// ----------------------------------------------------------------
`define BSFM_FAULT_NONE 3'h0
`define BSFM_FAULT_OVP 3'h1
`define BSFM_FAULT_START 3'h2
`define BSFM_FAULT_UVLO 3'h3
`define BSFM_FAULT_THERMAL 3'h5
`define BSFM_FAULT_TIMER 3'h6

// ----------------------------------------------------------------
// Times in ns and derived cycle counts at 50 MHz
// ----------------------------------------------------------------
`define BSFM_CLK_NS 20
`define BSFM_PRECHARGE_NS 560000
`define BSFM_SS1_NS 128000
`define BSFM_SS2_NS 384000
`define BSFM_ILIM_NS 50000
`define BSFM_STATUS_NS 128000
`define BSFM_RESTART_NS 5200000
`define BSFM_RETRY_NS 5000000
`define BSFM_PRECHARGE_CYC (`BSFM_PRECHARGE_NS / `BSFM_CLK_NS)
`define BSFM_SS1_CYC (`BSFM_SS1_NS / `BSFM_CLK_NS)
`define BSFM_SS2_CYC (`BSFM_SS2_NS / `BSFM_CLK_NS)
`define BSFM_ILIM_CYC (`BSFM_ILIM_NS / `BSFM_CLK_NS)
`define BSFM_STATUS_CYC (`BSFM_STATUS_NS / `BSFM_CLK_NS)
`define BSFM_RESTART_CYC (`BSFM_RESTART_NS / `BSFM_CLK_NS)
`define BSFM_RETRY_CYC (`BSFM_RETRY_NS / `BSFM_CLK_NS)

`endif

// ### test/bsfm_boost_monitor_props.sv
// Port-level assertions for the boost startup and fault monitor
`timescale 1ns/10ps
module bsfm_boost_monitor_props #(
    parameter int RESTART_CYC = 50,
    parameter int RETRY_CYC = 50
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire bsfm_pkg::bsfm_analog_t analog,
    input wire logic otg_pin,
    input wire logic otg_pin_enable,
    input wire logic otg_polarity_bit,
    input wire logic high_impedance_bit,
    input wire logic aux_regulator_disable,
    input wire logic request_set,
    input wire logic [7:0] monitor_live,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic boost_request_bit,
    input wire logic [2:0] fault_code,
    input wire logic status_out,
    input wire logic status_oe,
    input wire logic aux_regulator_output,
    input wire bsfm_pkg::bsfm_stage_t stage
);
    // ----------------------------------------
    // Clocking and reset for every check
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    AST_MON_READ: assert property (
        reg_addr == 8'h10 |=> reg_rdata == $past(monitor_live)) else $error("monitor read bad");
    AST_MON_OTHER: assert property (
        reg_addr != 8'h10 |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    AST_NO_RSVD_CODE: assert property (
        fault_code != 3'h4 && fault_code != 3'h7) else $error("reserved fault code");
    AST_FAULT_ACTIONS: assert property (
        $changed(fault_code) && fault_code != 3'h0 |-> status_oe && stage.stage_hiz
        && !boost_request_bit) else $error("fault actions missing");
    AST_STATUS_PULSE: assert property (
        $rose(status_oe) |-> (status_oe && !status_out) [*8]) else $error("status pulse short");
    AST_SKIP_HOLD: assert property (
        stage.pulse_skip_mode && analog.out_above_ref |=> !stage.switch_on)
        else $error("pulse in skip mode");
    AST_FB_OFF: assert property (
        stage.regulate_state && analog.fb_above_ref |=> !stage.switch_on)
        else $error("switch on above reference");
    AST_LONG_TON: assert property (
        stage.pulse_skip_mode |-> stage.long_ton) else $error("short on-time in skip");
    AST_FULL_LIMIT: assert property (
        stage.regulate_state |-> !stage.half_ilim) else $error("half limit in regulate");
    AST_START: assert property (
        $rose(boost_request_bit) && analog.bat_above_uvlo |=> stage.precharge_on)
        else $error("no precharge after start");
    AST_HIZ_REFUSE: assert property (
        request_set && high_impedance_bit |=> !boost_request_bit) else $error("request taken");
    AST_AUX_DIS: assert property (
        $past(aux_regulator_disable) |-> !aux_regulator_output) else $error("aux on disabled");
    AST_AUX_OFF: assert property (
        $past(high_impedance_bit) || stage.regulate_state |-> !aux_regulator_output)
        else $error("aux on while boosting");
    AST_AUX_MID: assert property (
        !$past(analog.mid_above_bat) |-> !aux_regulator_output) else $error("aux on low mid");
endmodule : bsfm_boost_monitor_props

bind bsfm_boost_monitor bsfm_boost_monitor_props #(
    .RESTART_CYC(RESTART_CYC),
    .RETRY_CYC(RETRY_CYC)
) u_props (.*);

// ### test/bsfm_boost_monitor_tb.sv
// Self-checking bench for the boost startup and fault monitor
`timescale 1ns/10ps
module bsfm_boost_monitor_tb;
    localparam int RESTART_CYC = 50; // Shortened restart delay
    localparam int RETRY_CYC = 50; // Shortened retry interval
    logic clk_sys = 1'h0;
    logic reset_n = 1'h0;
    bsfm_pkg::bsfm_analog_t tb_in = '0; // Bench comparator levels
    bsfm_pkg::bsfm_analog_t analog;
    logic otg_pin = 1'h0;
    logic otg_pin_enable = 1'h0;
    logic otg_polarity_bit = 1'h0;
    logic high_impedance_bit = 1'h0;
    logic aux_regulator_disable = 1'h0;
    logic request_set = 1'h0;
    logic [7:0] monitor_live = 8'h00;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_rdata, a, v;
    logic boost_request_bit, status_out, status_oe, aux_regulator_output;
    logic [2:0] fault_code, want;
    bsfm_pkg::bsfm_stage_t stage;
    int mid_delay = 20;
    int mismatches = 0;
    int checks = 0;
    int seed = 32'h6AD3;
    int n;
    // Fault injections and the codes they must give
    logic [12:0] msk [4] = '{13'h0004, 13'h0002, 13'h0001, 13'h0040};
    logic [2:0] code [4] = '{3'h1, 3'h5, 3'h6, 3'h3};
    initial forever #10 clk_sys = ~clk_sys;
    bsfm_boost_monitor #(.RESTART_CYC(RESTART_CYC), .RETRY_CYC(RETRY_CYC)) DUT (.*);
    bsfm_vbus_model u_load (.clk_sys(clk_sys), .reset_n(reset_n), .stage(stage),
        .mid_delay(mid_delay), .tb_in(tb_in), .analog(analog));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask : tick
    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'h1) begin
            mismatches++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : chk
    function automatic logic seen(input int w);
        case (w)
            0: return stage.regulate_state;
            1: return fault_code == want;
            2: return stage.precharge_on;
            default: return !status_oe;
        endcase
    endfunction : seen
    // Bounded wait, cycles spent left in n
    task automatic wait_on(input int w, input int lim);
        n = 0;
        while (seen(w) !== 1'h1 && n < lim) begin
            tick(1);
            #1;
            n++;
        end
    endtask : wait_on
    task automatic req();
        tick(1);
        request_set <= 1'h1;
        tick(1);
        request_set <= 1'h0;
    endtask : req
    function automatic logic [7:0] exp_rd(input logic [7:0] ad, input logic [7:0] live);
        return (ad == 8'h10) ? live : 8'h00;
    endfunction : exp_rd
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    // Hang guard
    initial begin
        tick(60000);
        mismatches++;
        test_done();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        tick(3);
        reset_n <= 1'h1;
        #1;
        chk({stage, fault_code, status_oe, aux_regulator_output, boost_request_bit}
            === 13'h0500, "reset values");
        tick(1);
        tb_in.bat_above_uvlo <= 1'h1;
        repeat (8) begin
            tick(1);
            a = ($random(seed) & 1) ? 8'h10 : 8'($random(seed));
            v = 8'($random(seed));
            reg_addr <= a;
            monitor_live <= v;
            tick(1);
            #1;
            chk(reg_rdata === exp_rd(a, v), "monitor read");
        end
        req();
        tick(1);
        #1;
        chk(boost_request_bit === 1'h1, "request bit");
        tick(1);
        #1;
        chk(stage.precharge_on === 1'h1, "precharge");
        wait_on(0, 2000);
        chk(stage.regulate_state === 1'h1 && stage.half_ilim === 1'h0, "regulate");
        // Stir the loop comparators so pulse skip is entered and left
        repeat (300) begin
            tick(1);
            tb_in.out_above_ref <= 1'($random(seed));
            tb_in.fb_above_ref <= 1'($random(seed));
            tb_in.izero <= 1'($random(seed));
            aux_regulator_disable <= 1'($random(seed));
        end
        high_impedance_bit <= 1'h1;
        req();
        reg_addr <= 8'h10;
        monitor_live <= 8'h02;
        tick(3);
        #1;
        chk(boost_request_bit === 1'h0 && stage.precharge_on === 1'h0, "refused");
        chk(reg_rdata[1] === 1'h1 && reg_rdata === 8'h02, "valid in high impedance");
        tick(1);
        high_impedance_bit <= 1'h0;
        mid_delay = 1000000000;
        want = 3'h2;
        req();
        wait_on(1, 28100);
        chk(seen(1) === 1'h1 && n > 27900, "precharge timeout");
        wait_on(3, 7000);
        chk(n >= 6397 && n <= 6401, "status width");
        tick(200);
        #1;
        chk(stage.precharge_on === 1'h0 && fault_code === 3'h2, "no restart");
        mid_delay = 20;
        tick(1);
        v[0] = 1'($random(seed));
        otg_polarity_bit <= v[0];
        otg_pin <= v[0];
        otg_pin_enable <= 1'h1;
        wait_on(0, 2000);
        for (int i = 0; i < 4; i++) begin
            want = code[i];
            tick(1);
            tb_in <= tb_in ^ msk[i];
            wait_on(1, 50);
            chk(seen(1) === 1'h1, "fault code");
            tick(1);
            tb_in <= tb_in ^ msk[i];
            wait_on(2, 200);
            chk(n >= RESTART_CYC - 5 && n <= RESTART_CYC + 3, "restart delay");
            wait_on(0, 2000);
        end
        test_done();
    end
endmodule : bsfm_boost_monitor_tb

// ### test/bsfm_vbus_model.sv
// Battery, mid rail and bus load model answering the power stage
`timescale 1ns/10ps
module bsfm_vbus_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire bsfm_pkg::bsfm_stage_t stage,
    input var int mid_delay,
    input wire bsfm_pkg::bsfm_analog_t tb_in,
    output bsfm_pkg::bsfm_analog_t analog
);
    int pre_cnt; // Precharge cycles delivered
    int sw_cnt; // Cycles since switching began
    // Charge builds while driven, drains once the stage floats
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pre_cnt <= 0;
            sw_cnt <= 0;
        end else if (stage.precharge_on) begin
            pre_cnt <= pre_cnt + 1;
        end else if (stage.stage_hiz) begin
            pre_cnt <= 0;
            sw_cnt <= 0;
        end else begin
            sw_cnt <= sw_cnt + 1;
        end
    end
    // Comparators seen by the block
    always_comb begin
        analog = tb_in;
        analog.mid_rail_ok = pre_cnt >= mid_delay;
        analog.mid_above_bat = pre_cnt >= mid_delay;
        analog.vbus_near_set = sw_cnt >= 30;
        analog.vbus_at_target = sw_cnt >= 24;
        analog.toff_done = sw_cnt % 4 == 3;
    end
endmodule : bsfm_vbus_model
